/* bench/crb_core_regs_chk.sv */
// Purpose: port-level checks for the core register bank
// Assumes: one clock with synchronous active-high reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
module crb_core_regs_chk (
  input logic ref_clk,
  input logic rst,
  input logic bvalid,
  input logic rvalid,
  input logic [31:0] rdata,
  input logic [2:0] aluOp,
  input logic [7:0] aluA,
  input logic [7:0] aluB,
  input logic [7:0] aluResult,
  input logic [5:0] bankSelector,
  input logic globalIrqEnable,
  input logic extIrqEdgeSelect,
  input logic [15:0] memAddr,
  input logic memWrite,
  input logic memRead,
  input logic [7:0] memRdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A pointer aimed at a port itself must never reach memory
  a_self_read: assert property (
    memRead |-> !(memAddr[15:13] == 3'h0 && memAddr[6:1] == 6'h0))
    else $error("indirect read aimed at a port");
  a_self_write: assert property (
    memWrite |-> !(memAddr[15:13] == 3'h0 && memAddr[6:1] == 6'h0))
    else $error("indirect write aimed at a port");
  // Memory data must come back on the bus one cycle later
  a_ind_data: assert property (
    memRead |=> rvalid && rdata[7:0] == $past(memRdata))
    else $error("indirect read data lost");
  // Reset values seen right after release
  a_edge_reset: assert property (
    $past(rst) |-> extIrqEdgeSelect && !globalIrqEnable)
    else $error("interrupt control reset value wrong");
  a_bank_reset: assert property (
    $past(rst) |-> bankSelector == 6'h0)
    else $error("bank selector reset value wrong");
  // Arithmetic results, subtraction as two's complement add
  a_add_sum: assert property (
    aluOp == 3'h1 |-> aluResult == 8'(aluA + aluB))
    else $error("add result wrong");
  a_sub_twos: assert property (
    aluOp == 3'h2 |-> aluResult == 8'(aluA + ~aluB + 8'h01))
    else $error("subtract result wrong");
  // The enable moves only with a completed register write
  a_gie_by_write: assert property (
    !$past(rst) && $changed(globalIrqEnable) |-> $rose(bvalid))
    else $error("global enable changed without a write");
endmodule // crb_core_regs_chk
bind crb_core_regs crb_core_regs_chk u_chk (.*);

/* bench/crb_mem_model.sv */
// Purpose: data memory that answers the indirect port accesses
// Assumes: the block samples memRdata at the edge that ends memRead
// Notes: only the low address byte is decoded, so addresses alias
`timescale 1ns/1ps
module crb_mem_model (
  input logic ref_clk,
  input logic [15:0] memAddr,
  input logic memWrite,
  input logic memRead,
  input logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  logic [7:0] mem [256];
  logic [7:0] junk = 8'h5a;
  // Store redirected writes; idle data toggles so a stale sample shows up
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (memWrite) mem[memAddr[7:0]] <= memWdata;
  end
  assign memRdata = memRead ? mem[memAddr[7:0]] : junk;
endmodule // crb_mem_model

/* bench/test_crb_core_regs.sv */
// Purpose: register, flag and indirect access tests for the core register bank
// Assumes: readies may answer at once; bready and rready are held high throughout
// Notes: byte address is four times the register index
`timescale 1ns/1ps
module test_crb_core_regs;
  logic ref_clk = 0, rst = 1, por = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 1, rready = 1, watchdogClearInstr = 0, sleepInstr = 0, watchdogTimeout = 0;
  logic [14:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'h1;
  logic [2:0] aluOp = 0;
  logic [7:0] aluA = 0, aluB = 0, v;
  wire awready, wready, bvalid, arready, rvalid, memWrite, memRead;
  wire globalIrqEnable, periphIrqEnable, extIrqEdgeSelect;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] aluResult, workingAccumulator, memWdata, memRdata;
  wire [14:0] programCounter;
  wire [5:0] bankSelector;
  wire [15:0] memAddr;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  crb_core_regs uut (.*);
  crb_mem_model mem (.*);
  always #12.5 ref_clk = ~ref_clk;
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Readies are sampled before the edge, so a channel drops only once it was really taken
  task wr(input [11:0] i, input [7:0] d);
    logic a, w, ta, tw, b;
    awaddr <= {1'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    a = 1'b1;
    w = 1'b1;
    #1;
    while (a || w) begin
      ta = a && awready;
      tw = w && wready;
      @(posedge ref_clk);
      #1;
      if (ta) begin
        awvalid <= 1'h0;
        a = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'h0;
        w = 1'b0;
      end
    end
    do begin
      b = bvalid;
      @(posedge ref_clk);
      #1;
    end while (!b);
  endtask
  task rd(input [11:0] i, output [7:0] d);
    logic g;
    araddr <= {1'h0, i, 2'h0};
    arvalid <= 1'h1;
    #1;
    do begin
      g = arready;
      @(posedge ref_clk);
      #1;
    end while (!g);
    arvalid <= 1'h0;
    do begin
      g = rvalid;
      d = rdata[7:0];
      @(posedge ref_clk);
      #1;
    end while (!g);
  endtask
  task rc(input [11:0] i, input [7:0] e);
    rd(i, v);
    chk(v, e);
  endtask
  task rs(input p);
    por <= p;
    rst <= 1'h1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
  endtask
  task pulse(input [2:0] s);
    {watchdogClearInstr, sleepInstr, watchdogTimeout} <= s;
    @(posedge ref_clk);
    {watchdogClearInstr, sleepInstr, watchdogTimeout} <= 3'h0;
    @(posedge ref_clk);
  endtask
  // Rotate results hang on the old carry, so only their flag is compared
  task af(input [2:0] o, input [7:0] a, b, r, m, s);
    aluOp <= o;
    aluA <= a;
    aluB <= b;
    #1;
    if (o < 3'h4) chk(aluResult, r);
    @(posedge ref_clk);
    aluOp <= 3'h0;
    rd(12'h003, v);
    chk(v & m, s);
  endtask
  initial begin
    rs(1'h1);
    rc(12'h003, 8'h18);
    rc(12'h00b, 8'h01);
    pulse(3'h1);
    rc(12'h003, 8'h08);
    wr(12'h003, 8'h17);
    rc(12'h003, 8'h0f);
    pulse(3'h2);
    rc(12'h003, 8'h17);
    wr(12'h003, 8'h08);
    rc(12'h003, 8'h10);
    pulse(3'h4);
    rc(12'h003, 8'h18);
    af(3'h1, 8'h0f, 8'h01, 8'h10, 8'h07, 8'h02);
    af(3'h1, 8'hff, 8'h01, 8'h00, 8'h07, 8'h07);
    af(3'h2, 8'h05, 8'h05, 8'h00, 8'h07, 8'h07);
    af(3'h2, 8'h03, 8'h05, 8'hfe, 8'h07, 8'h00);
    af(3'h3, 8'hf0, 8'h0f, 8'h00, 8'h04, 8'h04);
    af(3'h4, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01);
    af(3'h5, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00);
    wr(12'h003, 8'h05);
    rs(1'h0);
    rc(12'h003, 8'h1d);
    rs(1'h1);
    rc(12'h003, 8'h18);
    wr(12'h004, 8'h34);
    wr(12'h005, 8'h12);
    rc(12'h005, 8'h12);
    rc(12'h284, 8'h34);
    wr(12'h000, 8'ha5);
    rc(12'h000, 8'ha5);
    wr(12'h006, 8'h80);
    wr(12'h001, 8'h5a);
    rc(12'h001, 8'h00);
    wr(12'h008, 8'hff);
    chk(bankSelector, 6'h3f);
    wr(12'h00a, 8'hff);
    rc(12'h00a, 8'h7f);
    wr(12'h002, 8'h55);
    chk(programCounter, 15'h7f55);
    rc(12'h002, 8'h55);
    wr(12'h009, 8'h3c);
    chk(workingAccumulator, 8'h3c);
    wr(12'h00b, 8'hff);
    rc(12'h00b, 8'hc1);
    chk({globalIrqEnable, periphIrqEnable, extIrqEdgeSelect}, 3'h7);
    wr(12'h00b, 8'h00);
    chk({globalIrqEnable, periphIrqEnable, extIrqEdgeSelect}, 3'h0);
    wr(12'hfed, 8'h03);
    wr(12'hfee, 8'h11);
    wr(12'hfef, 8'h22);
    wr(12'hfed, 8'h04);
    wr(12'hfee, 8'h33);
    rc(12'hfee, 8'h33);
    wr(12'hfed, 8'h03);
    rc(12'hfef, 8'h22);
    wr(12'hfed, 8'hff);
    rc(12'hfed, 8'h1f);
    rc(12'h00c, 8'h00);
    report_and_stop;
  end
endmodule // test_crb_core_regs

/* rtl/crb_consts.vh */
// Purpose: constants for the core register bank (offsets, fields, resets)
// Assumes: byte-wide registers; printed offsets are word indices on AXI4-Lite
// Notes: byte address on the bus is four times the index
//
// What this block does
// - Indirect data ports access data memory at their 16-bit pointer address.
// - Core registers decode at same low offset in every 0x80 bank, 32 banks.
// - Program counter low byte is readable and writable; a write changes it.
// - Timeout flag bit 4 read-only; set by power-up/clear/sleep, cleared on timeout.
// - Power-down flag bit 3 read-only; set by power-up/clear, cleared by sleep.
// - Zero flag bit 2 set when an add/subtract/logic result is zero, else cleared.
// - Half-carry bit 1 is carry out of bit 3 for add/subtract.
// - Carry bit 0 is carry out of bit 7 for add/subtract.
// - Subtract adds two's complement; rotates load carry from end bit.
// - Power-on reset sets timeout/power-down, clears arithmetic flags; others keep them.
// - Each indirect pointer has separately accessible high and low bytes.
// - Six-bit bank selector supplies upper direct address bits.
// - Seven-bit latch holds upper program counter bits for later transfer.
// - Global enable bit 7 gates every interrupt.
// - Peripheral enable bit 6 gates peripheral interrupts.
// - Bit 0 selects external edge, 1 rising, resets to 1.
// - Interrupt flags set regardless of enables so software can poll.
// - Top-of-stack pair shows the stack entry chosen by the stack pointer.
// - Five-bit stack pointer holds the current stack location.
// - Pointer aimed at an indirect port reads zero and suppresses writes.
`ifndef CRB_CONSTS_VH
`define CRB_CONSTS_VH
`define CRB_IDX_IND0 12'h000
`define CRB_IDX_IND1 12'h001
`define CRB_IDX_PCL 12'h002
`define CRB_IDX_STAT 12'h003
`define CRB_IDX_P0L 12'h004
`define CRB_IDX_P0H 12'h005
`define CRB_IDX_P1L 12'h006
`define CRB_IDX_P1H 12'h007
`define CRB_IDX_BANK 12'h008
`define CRB_IDX_WACC 12'h009
`define CRB_IDX_PCHL 12'h00a
`define CRB_IDX_ICON 12'h00b
`define CRB_IDX_CORE 12'h00c
`define CRB_IDX_SIDX 12'hfed
`define CRB_IDX_STL 12'hfee
`define CRB_IDX_STH 12'hfef
`define CRB_BANK_MASK 12'h07f
`define CRB_BIT_TO 4
`define CRB_BIT_PD 3
`define CRB_BIT_Z 2
`define CRB_BIT_DC 1
`define CRB_BIT_C 0
`define CRB_BIT_GIE 7
`define CRB_BIT_PERIPH_IRQ_ENABLE 6
`define CRB_BIT_EDGE 0
`define CRB_RST_STAT 5'h18
`define CRB_RST_ICON 8'h01
`define CRB_OP_NONE 3'h0
`define CRB_OP_ADD 3'h1
`define CRB_OP_SUB 3'h2
`define CRB_OP_LOGIC 3'h3
`define CRB_OP_RLC 3'h4
`define CRB_OP_RRC 3'h5
`define CRB_RESP_OKAY 2'h0
`define CRB_RESP_SLVERR 2'h2
`endif

/* rtl/crb_core_regs.v */
// Purpose: CPU core register bank reached over AXI4-Lite and the execute core
// Assumes: one clock, synchronous active-high reset; por marks a power-on reset
// Notes: indirect port accesses leave through the memory port, one cycle each
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "crb_consts.vh"
module crb_core_regs #(
  parameter STACK_DEPTH = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire por,
  input wire [14:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [14:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [2:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  output reg [7:0] aluResult,
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  output wire [14:0] programCounter,
  output wire [5:0] bankSelector,
  output wire [7:0] workingAccumulator,
  output wire globalIrqEnable,
  output wire periphIrqEnable,
  output wire extIrqEdgeSelect,
  output reg [15:0] memAddr,
  output reg memWrite,
  output reg memRead,
  output reg [7:0] memWdata,
  input wire [7:0] memRdata
);
  // Architectural state
  // Every register here is one byte wide on the bus; the 16-bit pairs are
  // split into low and high bytes at neighbouring indices, low at the even
  // index. Software sees only lane 0 of the 32-bit data word.
  // The execute core owns the arithmetic unit inputs; software owns the
  // register writes. Where both touch the status byte in one cycle, the
  // hardware result wins, since the instruction stream is authoritative.
  reg [7:0] pcLow_q;
  reg [6:0] pcHigh_q;
  reg [6:0] pcLatch_q;
  reg [4:0] status_q;
  reg [15:0] ptr0_q;
  reg [15:0] ptr1_q;
  reg [5:0] bank_q;
  reg [7:0] wacc_q;
  reg [7:0] icon_q;
  reg [4:0] sidx_q;
  reg [15:0] stack_q [0:STACK_DEPTH-1];
  // Bus sequencing
  reg awHeld_q;
  reg wHeld_q;
  reg [11:0] awIdx_q;
  reg [7:0] wByte_q;
  reg wLane_q;
  reg rdWait_q;
  integer i;

  // Address taken and data taken independently; response when both held
  // Each channel is refused while its item is held or a response stands,
  // so at most one write is in flight. A master that parks its valid on a
  // channel after the handshake would start a second write once the
  // response is taken; the master must drop valid at the taking edge.
  // Reads are independent of writes, but an indirect read in the cycle of an
  // indirect memory write raises no read strobe; a read and a write at the
  // same register index in one cycle see the old value on the read side.
  assign awready = !awHeld_q && !bvalid;
  assign wready = !wHeld_q && !bvalid;
  assign arready = !rvalid && !rdWait_q;
  wire doWrite = awHeld_q && wHeld_q && !bvalid;
  wire doRead = arvalid && arready;
  wire [11:0] arIdx = araddr[13:2];

  // Fold banked indices so core registers repeat every 0x80
  // Only the twelve core indices alias; the stack registers sit at fixed
  // high indices and are not repeated. Anything else reads zero.
  function [11:0] foldIdx;
    input [11:0] idx;
    begin
      if ((idx & `CRB_BANK_MASK) < `CRB_IDX_CORE)
        foldIdx = idx & `CRB_BANK_MASK;
      else
        foldIdx = idx;
    end
  endfunction

  // Pointer aimed at a port itself, in any bank
  // Only the banked region (top three bits clear) can hold a port; the
  // linear and program regions never map back onto the ports.
  function isPort;
    input [15:0] a;
    begin
      isPort = (a[15:13] == 3'h0) && ((a[6:0] == 7'h00) || (a[6:0] == 7'h01));
    end
  endfunction

  wire [11:0] wIdx = foldIdx(awIdx_q);
  wire [11:0] rIdx = foldIdx(arIdx);
  wire wrHit = doWrite && wLane_q;
  wire [4:0] sAddr = (sidx_q < STACK_DEPTH) ? sidx_q : 5'h00;
  wire [15:0] stackTop = stack_q[sAddr[3:0]];

  // Arithmetic unit: subtract is add of two's complement
  // The carry out of a subtract is therefore an inverted borrow: set when
  // no borrow occurred. The nibble sum gives the half carry the same way.
  // Rotates consume the stored carry, so their result depends on history.
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] opB;
  reg cIn;
  always @* begin
    opB = (aluOp == `CRB_OP_SUB) ? ~aluB : aluB;
    cIn = (aluOp == `CRB_OP_SUB);
    sum = {1'b0, aluA} + {1'b0, opB} + {8'h00, cIn};
    nib = {1'b0, aluA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cIn};
    case (aluOp)
      `CRB_OP_ADD, `CRB_OP_SUB: aluResult = sum[7:0];
      `CRB_OP_RLC: aluResult = {aluA[6:0], status_q[`CRB_BIT_C]};
      `CRB_OP_RRC: aluResult = {status_q[`CRB_BIT_C], aluA[7:1]};
      default: aluResult = aluA & aluB;
    endcase
  end

  // Status flags; hardware events beat software writes to writable bits
  // A reset without the power-on qualifier keeps every flag, so software
  // can tell a timeout reset from a cold start by reading the timeout bit.
  // Timeout and power-down bits cannot be written from the bus.
  always @(posedge ref_clk) begin
    if (rst && por) begin
      status_q <= `CRB_RST_STAT;
    end else if (rst) begin
      status_q[`CRB_BIT_TO] <= status_q[`CRB_BIT_TO];
    end else begin
      if (wrHit && wIdx == `CRB_IDX_STAT)
        status_q[2:0] <= wByte_q[2:0];
      if (aluOp == `CRB_OP_ADD || aluOp == `CRB_OP_SUB) begin
        status_q[`CRB_BIT_Z] <= (sum[7:0] == 8'h00);
        status_q[`CRB_BIT_DC] <= nib[4];
        status_q[`CRB_BIT_C] <= sum[8];
      end else if (aluOp == `CRB_OP_LOGIC) begin
        status_q[`CRB_BIT_Z] <= ((aluA & aluB) == 8'h00);
      end else if (aluOp == `CRB_OP_RLC) begin
        status_q[`CRB_BIT_C] <= aluA[7];
      end else if (aluOp == `CRB_OP_RRC) begin
        status_q[`CRB_BIT_C] <= aluA[0];
      end
      // Timeout wins over clear so a timeout is never lost
      if (watchdogTimeout)
        status_q[`CRB_BIT_TO] <= 1'b0;
      else if (watchdogClearInstr || sleepInstr)
        status_q[`CRB_BIT_TO] <= 1'b1;
      if (sleepInstr)
        status_q[`CRB_BIT_PD] <= 1'b0;
      else if (watchdogClearInstr)
        status_q[`CRB_BIT_PD] <= 1'b1;
    end
  end

  // Software-visible registers
  // The upper program counter bits move only on a low-byte write, so a
  // latch write alone never disturbs the running program.
  // The stack window follows the index at once; an index beyond the depth
  // falls back to entry zero rather than reading undriven storage.
  always @(posedge ref_clk) begin
    if (rst) begin
      pcLow_q <= 8'h00;
      pcHigh_q <= 7'h00;
      pcLatch_q <= 7'h00;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      bank_q <= 6'h00;
      wacc_q <= 8'h00;
      icon_q <= `CRB_RST_ICON;
      sidx_q <= 5'h00;
      for (i = 0; i < STACK_DEPTH; i = i + 1)
        stack_q[i] <= 16'h0000;
    end else if (wrHit) begin
      case (wIdx)
        `CRB_IDX_PCL: begin
          pcLow_q <= wByte_q;
          pcHigh_q <= pcLatch_q;
        end
        `CRB_IDX_P0L: ptr0_q[7:0] <= wByte_q;
        `CRB_IDX_P0H: ptr0_q[15:8] <= wByte_q;
        `CRB_IDX_P1L: ptr1_q[7:0] <= wByte_q;
        `CRB_IDX_P1H: ptr1_q[15:8] <= wByte_q;
        `CRB_IDX_BANK: bank_q <= wByte_q[5:0];
        `CRB_IDX_WACC: wacc_q <= wByte_q;
        `CRB_IDX_PCHL: pcLatch_q <= wByte_q[6:0];
        `CRB_IDX_ICON: icon_q <= wByte_q & 8'hc1;
        `CRB_IDX_SIDX: sidx_q <= wByte_q[4:0];
        `CRB_IDX_STL: stack_q[sAddr[3:0]][7:0] <= wByte_q;
        `CRB_IDX_STH: stack_q[sAddr[3:0]][15:8] <= wByte_q;
        default: pcLow_q <= pcLow_q;
      endcase
    end
  end

  // Enables drive the interrupt controller outside; flags live there
  assign globalIrqEnable = icon_q[`CRB_BIT_GIE];
  assign periphIrqEnable = icon_q[`CRB_BIT_PERIPH_IRQ_ENABLE];
  assign extIrqEdgeSelect = icon_q[`CRB_BIT_EDGE];
  assign programCounter = {pcHigh_q, pcLow_q};
  assign bankSelector = bank_q;
  assign workingAccumulator = wacc_q;

  // Indirect access target; concern flags held elsewhere
  wire wIsInd = (wIdx == `CRB_IDX_IND0) || (wIdx == `CRB_IDX_IND1);
  wire rIsInd = (rIdx == `CRB_IDX_IND0) || (rIdx == `CRB_IDX_IND1);
  wire [15:0] wPtr = (wIdx == `CRB_IDX_IND1) ? ptr1_q : ptr0_q;
  wire [15:0] rPtr = (rIdx == `CRB_IDX_IND1) ? ptr1_q : ptr0_q;
  reg rdZero_q;

  // Memory port strobes, one cycle, data from flip-flops
  // The write strobe follows the bus write by one cycle; the read strobe
  // is raised in the cycle before the bus answer, and the memory must
  // return its data within that cycle. A self-aimed access raises no
  // strobe at all and answers zero, so memory is never disturbed.
  always @(posedge ref_clk) begin
    if (rst) begin
      memAddr <= 16'h0000;
      memWrite <= 1'b0;
      memRead <= 1'b0;
      memWdata <= 8'h00;
      rdZero_q <= 1'b0;
    end else begin
      memWrite <= 1'b0;
      memRead <= 1'b0;
      if (wrHit && wIsInd && !isPort(wPtr)) begin
        memAddr <= wPtr;
        memWrite <= 1'b1;
        memWdata <= wByte_q;
      end else if (doRead && rIsInd) begin
        memAddr <= rPtr;
        memRead <= !isPort(rPtr);
        rdZero_q <= isPort(rPtr);
      end
    end
  end

  // Register read mux; unmapped reads as zero with OKAY
  // Reserved bits of every register read as zero; the ports themselves
  // have no storage and are answered through the memory path instead.
  reg [7:0] rByte;
  always @* begin
    case (rIdx)
      `CRB_IDX_PCL: rByte = pcLow_q;
      `CRB_IDX_STAT: rByte = {3'h0, status_q};
      `CRB_IDX_P0L: rByte = ptr0_q[7:0];
      `CRB_IDX_P0H: rByte = ptr0_q[15:8];
      `CRB_IDX_P1L: rByte = ptr1_q[7:0];
      `CRB_IDX_P1H: rByte = ptr1_q[15:8];
      `CRB_IDX_BANK: rByte = {2'h0, bank_q};
      `CRB_IDX_WACC: rByte = wacc_q;
      `CRB_IDX_PCHL: rByte = {1'b0, pcLatch_q};
      `CRB_IDX_ICON: rByte = icon_q;
      `CRB_IDX_SIDX: rByte = {3'h0, sidx_q};
      `CRB_IDX_STL: rByte = stackTop[7:0];
      `CRB_IDX_STH: rByte = stackTop[15:8];
      default: rByte = 8'h00;
    endcase
  end

  // Write channel capture and response
  // Lane 0 carries the byte; a write with that lane off is answered OKAY
  // and changes nothing, which keeps partial-word writes harmless.
  // The response is always OKAY: there are no error cases to report.
  always @(posedge ref_clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awIdx_q <= 12'h000;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `CRB_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awIdx_q <= awaddr[13:2];
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0]; // Only lane 0 carries register bits
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `CRB_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel; indirect reads wait one cycle for memory data
  // Direct reads answer one cycle after the address is taken, indirect
  // reads two; the address channel stays refused until the answer is
  // taken, so read data can never be overwritten before it is seen.
  // Holding rdata in flip-flops costs a cycle but keeps the bus output
  // free of the memory's combinational path.
  always @(posedge ref_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CRB_RESP_OKAY;
      rdWait_q <= 1'b0;
    end else if (doRead && rIsInd) begin
      rdWait_q <= 1'b1;
    end else if (rdWait_q) begin
      rdWait_q <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `CRB_RESP_OKAY;
      rdata <= {24'h000000, rdZero_q ? 8'h00 : memRdata};
    end else if (doRead) begin
      rvalid <= 1'b1;
      rresp <= `CRB_RESP_OKAY;
      rdata <= {24'h000000, rByte};
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // crb_core_regs
